// ### hw/nbc_addr_split.sv
/*
 * Address cycle splitter: maps a flat address and a cycle index onto
 * the low I/O lines for byte or word organization.
 * Assumes index 0..4; unused lines are forced low.
 */
`timescale 1ns/10ps
`include "nbc_params.svh"

module nbc_addr_split (
    // Selection
    input  wire logic [`NBC_ADDR_W-1:0] i_addr,
    input  wire logic [2:0]             i_idx,
    input  wire logic                   i_wide,
    // Cycle value
    output logic      [7:0]             o_byte
);

    // -----------------------------------------------------------------
    // Byte and word maps
    // -----------------------------------------------------------------
    logic [7:0] byte_map;
    logic [7:0] word_map;

    // Byte-wide map: 8,4,8,8,1 bits
    always_comb begin
        unique case (i_idx)
            3'd0:    byte_map = i_addr[7:0];
            3'd1:    byte_map = {4'h0, i_addr[11:8]};
            3'd2:    byte_map = i_addr[19:12];
            3'd3:    byte_map = i_addr[27:20];
            3'd4:    byte_map = {7'h00, i_addr[28]};
            default: byte_map = 8'h00;
        endcase
    end

    // Word-wide map: 8,3,8,8,1 bits
    always_comb begin
        unique case (i_idx)
            3'd0:    word_map = i_addr[7:0];
            3'd1:    word_map = {5'h00, i_addr[10:8]};
            3'd2:    word_map = i_addr[18:11];
            3'd3:    word_map = i_addr[26:19];
            3'd4:    word_map = {7'h00, i_addr[27]};
            default: word_map = 8'h00;
        endcase
    end

    assign o_byte = i_wide ? word_map : byte_map;

endmodule

// ### hw/nbc_host.sv
/*
 * NAND bus host: drives chip select, latch selects, write and read
 * strobes and the shared I/O bus, one bus cycle per user request, five for NBC_OP_ADDR5.
 * Assumes the flash pins are synchronous to i_clk; the busy line is
 * open drain and pulled up outside, read here as a plain input.
 */
`timescale 1ns/10ps
`include "nbc_params.svh"

// Behaviour
// - Chip select high means standby; host drives it low only in cycles.
// - Byte mode sends five address cycles 8,4,8,8,1 bits, rest low.
// - Word mode sends 8,3,8,8,1 bits; upper lines low always.
// - Program, copy-back, two-plane and erase sequences use listed codes.
// - Read, cache, random output, ID, status, reset codes are listed.
// - Command/address cycle: one latch select, read strobe high, protect.
// - Data out: both latches low, write strobe high, read strobe toggles.
// - During program only status and reset commands are accepted.
// - Commands and addresses always sit on the low eight lines.
module nbc_host (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    // User request
    input  wire logic               i_req,
    input  wire logic [2:0]         i_op,
    input  wire logic [15:0]        i_data,
    input  wire logic [`NBC_ADDR_W-1:0] i_addr,
    input  wire logic               i_wide,
    input  wire logic               i_protect,
    output logic                    o_ready,
    // User answer
    output logic                    o_done,
    output logic [15:0]             o_rdata,
    output logic                    o_busy,
    output logic                    o_refused,
    // Flash pins
    output logic                    o_ce_b,
    output logic                    o_cle,
    output logic                    o_ale,
    output logic                    o_write_strobe_n,
    output logic                    o_read_strobe_n,
    output logic                    o_wp_b,
    input  wire logic [15:0]        i_io,
    output logic [15:0]             o_io,
    output logic [15:0]             o_io_oe,
    input  wire logic               i_rb
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    nbc_pkg::nbc_state_t state_ff, nxt_state;
    nbc_pkg::nbc_op_t    op_ff;
    logic [2:0]   cnt_ff;
    logic [2:0]   aidx_ff;
    logic [15:0]  dout_ff;
    logic [15:0]  rdata_ff;
    logic         done_ff;
    logic         refused_ff;
    logic         wide_ff;
    logic         prog_busy_ff;
    logic         rb_ff;
    logic [`NBC_ADDR_W-1:0] addr_ff;
    logic [7:0]   abyte;

    // Modify-starting command test, used once, by the protect check
    function automatic logic nbc_is_modify(input logic [7:0] c);
        nbc_is_modify = (c == `NBC_CMD_PROG) || (c == `NBC_CMD_RAND_IN) ||
                        (c == `NBC_CMD_PLANE2) || (c == `NBC_CMD_ERASE) ||
                        (c == `NBC_CMD_PROG_CONF) ||
                        (c == `NBC_CMD_DUMMY_CONF) ||
                        (c == `NBC_CMD_ERASE_CONF);
    endfunction

    // -----------------------------------------------------------------
    // Request decode
    // -----------------------------------------------------------------
    wire       idle      = (state_ff == nbc_pkg::NBC_ST_IDLE);
    wire       is_cmd    = (i_op == 3'(nbc_pkg::NBC_OP_CMD));
    wire       cmd_ok    = (i_data[7:0] == `NBC_CMD_STATUS) ||
                           (i_data[7:0] == `NBC_CMD_RESET);
    // Only status and reset pass while a program runs
    wire       blk_busy  = is_cmd && prog_busy_ff && !cmd_ok;
    // Modify without protect release is refused locally
    wire       blk_wp    = is_cmd && nbc_is_modify(i_data[7:0]) &&
                           !i_protect;
    wire       blk_op    = (i_op > 3'(nbc_pkg::NBC_OP_ADDR5));
    wire       take      = i_req && idle;
    wire       accept    = take && !blk_busy && !blk_wp && !blk_op;
    wire       cnt_end   = (cnt_ff == 3'(`NBC_STROBE_CYC - 1));
    wire       is_read   = (op_ff == nbc_pkg::NBC_OP_RDATA);
    wire       is_addr5  = (op_ff == nbc_pkg::NBC_OP_ADDR5);
    wire       last_addr = (aidx_ff == 3'(`NBC_ADDR_CYCLES - 1));
    wire       high_end  = (state_ff == nbc_pkg::NBC_ST_HIGH) && cnt_end;
    wire       finish    = high_end && (!is_addr5 || last_addr);

    // Address cycle value on the low lines
    nbc_addr_split u_split (
        .i_addr (addr_ff),
        .i_idx  (aidx_ff),
        .i_wide (wide_ff),
        .o_byte (abyte)
    );

    // -----------------------------------------------------------------
    // Strobe sequencer
    // -----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            nbc_pkg::NBC_ST_IDLE:
                if (accept) begin
                    nxt_state = nbc_pkg::NBC_ST_LOW;
                end
            nbc_pkg::NBC_ST_LOW:
                if (cnt_end) begin
                    nxt_state = nbc_pkg::NBC_ST_HIGH;
                end
            nbc_pkg::NBC_ST_HIGH:
                if (finish) begin
                    nxt_state = nbc_pkg::NBC_ST_IDLE;
                end else if (high_end) begin
                    nxt_state = nbc_pkg::NBC_ST_LOW;
                end
            default: nxt_state = nbc_pkg::NBC_ST_IDLE;
        endcase
    end

    // State and phase counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= nbc_pkg::NBC_ST_IDLE;
            cnt_ff   <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (nxt_state != state_ff) ? 3'h0 : cnt_ff + 3'h1;
        end
    end

    // Address cycle index steps at the end of each write strobe high phase but the last
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aidx_ff <= 3'h0;
        end else if (accept) begin
            aidx_ff <= 3'h0;
        end else if (high_end && is_addr5 && !last_addr) begin
            aidx_ff <= aidx_ff + 3'h1;
        end
    end

    // Request capture
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            op_ff   <= nbc_pkg::NBC_OP_CMD;
            dout_ff <= 16'h0000;
            addr_ff <= '0;
            wide_ff <= 1'b0;
        end else if (accept) begin
            op_ff   <= nbc_pkg::nbc_op_t'(i_op);
            // Commands and addresses keep upper lines low
            dout_ff <= (is_cmd || !i_wide ||
                        i_op == 3'(nbc_pkg::NBC_OP_ADDR))
                       ? {8'h00, i_data[7:0]} : i_data;
            addr_ff <= i_addr;
            wide_ff <= i_wide;
        end
    end

    // Read data sampled at the end of the low phase
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_ff <= 16'h0000;
        end else if (is_read && (state_ff == nbc_pkg::NBC_ST_LOW) &&
                     cnt_end) begin
            rdata_ff <= wide_ff ? i_io : {8'h00, i_io[7:0]};
        end
    end

    // Answer pulses and program-busy tracking
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_ff      <= 1'b0;
            refused_ff   <= 1'b0;
            prog_busy_ff <= 1'b0;
            rb_ff        <= 1'b1;
        end else begin
            done_ff    <= finish;
            refused_ff <= take && !accept;
            rb_ff      <= i_rb;
            // Confirm starts busy; ready or reset ends it
            if (accept && is_cmd &&
                ((i_data[7:0] == `NBC_CMD_PROG_CONF) ||
                 (i_data[7:0] == `NBC_CMD_ERASE_CONF))) begin
                prog_busy_ff <= 1'b1;
            end else if (accept && is_cmd &&
                         (i_data[7:0] == `NBC_CMD_RESET)) begin
                prog_busy_ff <= 1'b0;
            // Device turns busy only after the confirm strobe, so ready
            // counts only once the cycle is over
            end else if (rb_ff && i_rb && idle && !done_ff) begin
                prog_busy_ff <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Pin drive
    // -----------------------------------------------------------------
    wire active  = !idle;
    wire wr_kind = active && !is_read;
    wire lowph   = (state_ff == nbc_pkg::NBC_ST_LOW);

    // Chip select low only inside a cycle
    assign o_ce_b = !active;
    // Exactly one latch select for command or address
    assign o_cle  = active && (op_ff == nbc_pkg::NBC_OP_CMD);
    assign o_ale  = active && (is_addr5 || op_ff == nbc_pkg::NBC_OP_ADDR);
    // Write strobe rises at phase change while data holds
    assign o_write_strobe_n = !(wr_kind && lowph);
    // Read strobe stays high in write cycles
    assign o_read_strobe_n  = !(active && is_read && lowph);
    assign o_wp_b  = i_protect;
    // Bus is driven only in write-type cycles, released otherwise
    assign o_io    = is_addr5 ? {8'h00, abyte} : dout_ff;
    assign o_io_oe = wr_kind ? (wide_ff ? 16'hFFFF : 16'h00FF) : 16'h0000;
    assign o_ready   = idle;
    assign o_done    = done_ff;
    assign o_rdata   = rdata_ff;
    assign o_busy    = !i_rb;
    assign o_refused = refused_ff;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_low_ph;
        !o_write_strobe_n [*3];
    endsequence

    property p_wr_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_write_strobe_n) |-> $stable(o_io) && !o_ce_b;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("io moved");

    property p_release;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_ce_b |-> (o_io_oe == 16'h0000);
    endproperty
    a_release: assert property (p_release) else $error("bus driven");

    property p_one_latch;
        @(posedge i_clk) disable iff (!i_rst_b)
        !(o_cle && o_ale);
    endproperty
    a_one_latch: assert property (p_one_latch) else $error("two latch");

    property p_wr_pulse;
        @(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_write_strobe_n) |-> s_low_ph ##1 o_write_strobe_n;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("strobe width");

    property p_rd_quiet;
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_read_strobe_n |-> o_write_strobe_n && !o_cle && !o_ale;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read ctl");

    property p_wp_block;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_req && idle && is_cmd && !i_protect &&
         i_data[7:0] == `NBC_CMD_ERASE) |=> o_refused && o_ce_b;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("wp pass");

    property p_upper_low;
        @(posedge i_clk) disable iff (!i_rst_b)
        (o_cle || o_ale) |-> (o_io[15:8] == 8'h00);
    endproperty
    a_upper_low: assert property (p_upper_low) else $error("upper io");

    property p_addr_map;
        @(posedge i_clk) disable iff (!i_rst_b)
        (o_ale && !wide_ff && aidx_ff == 3'd1) |-> (o_io[7:4] == 4'h0);
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("addr map");

endmodule

// ### hw/nbc_params.svh
/*
 * Constants of the NAND bus host: command codes, address cycle layout
 * and strobe timing counts.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef NBC_PARAMS_SVH
`define NBC_PARAMS_SVH

// -----------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------
`define NBC_CMD_READ        8'h00
`define NBC_CMD_READ_CONF   8'h30
`define NBC_CMD_CB_READ     8'h35
`define NBC_CMD_CACHE_RAND  8'h31
`define NBC_CMD_CACHE_END   8'h3F
`define NBC_CMD_ROUT        8'h05
`define NBC_CMD_ROUT_CONF   8'hE0
`define NBC_CMD_READ_ID     8'h90
`define NBC_CMD_STATUS      8'h70
`define NBC_CMD_EDC_STATUS  8'h7B
`define NBC_CMD_RESET       8'hFF
`define NBC_CMD_PROG        8'h80
`define NBC_CMD_RAND_IN     8'h85
`define NBC_CMD_PROG_CONF   8'h10
`define NBC_CMD_DUMMY_CONF  8'h11
`define NBC_CMD_PLANE2      8'h81
`define NBC_CMD_ERASE       8'h60
`define NBC_CMD_ERASE_CONF  8'hD0

// -----------------------------------------------------------------
// Address cycles
// -----------------------------------------------------------------
`define NBC_ADDR_CYCLES     3'd5
`define NBC_ADDR_W          29

// -----------------------------------------------------------------
// Strobe timing (each phase of a strobe pulse)
// -----------------------------------------------------------------
`define NBC_CLK_NS          10
`define NBC_STROBE_NS       30
`define NBC_STROBE_CYC      ((`NBC_STROBE_NS + `NBC_CLK_NS - 1) / `NBC_CLK_NS)

`endif

// ### hw/nbc_pkg.sv
/*
 * Types of the NAND bus host.
 * Assumes nothing of its surroundings.
 */
package nbc_pkg;

    // Kind of one bus cycle requested by the user
    typedef enum logic [2:0] {
        NBC_OP_CMD   = 3'b000,
        NBC_OP_ADDR  = 3'b001,
        NBC_OP_WDATA = 3'b010,
        NBC_OP_RDATA = 3'b011,
        NBC_OP_ADDR5 = 3'b100
    } nbc_op_t;

    // Strobe sequencer states
    typedef enum logic [1:0] {
        NBC_ST_IDLE = 2'b00,
        NBC_ST_LOW  = 2'b01,
        NBC_ST_HIGH = 2'b10
    } nbc_state_t;

endpackage

// ### verif/nand_bus_command_decode_tb.sv
/*
 * Self-checking bench for the NAND bus host against the device model.
 * Assumes a 100 MHz clock and inputs changed on the falling edge.
 */
`timescale 1ns/10ps
`include "nbc_params.svh"

module nand_bus_command_decode_tb;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_req = 1'b0;
    logic i_wide = 1'b0, i_protect = 1'b1;
    logic [2:0] i_op = 3'h0;
    logic [15:0] i_data = 16'h0000;
    logic [`NBC_ADDR_W-1:0] i_addr = '0;
    logic o_ready, o_done, o_busy, o_refused, o_ce_b, o_cle, o_ale;
    logic o_write_strobe_n, o_read_strobe_n, o_wp_b, m_pull, rb;
    logic [15:0] o_rdata, o_io, o_io_oe, m_io, io_bus, oe_seen;
    logic [4:0]  pins;
    int          n_mismatch = 0;
    int          tests_run = 0;

    // -----------------------------------------------------------------
    // Wiring
    // -----------------------------------------------------------------
    // Each bit is the host's value while it drives, else the device's
    assign io_bus = (o_io & o_io_oe) | (m_io & ~o_io_oe);
    assign rb = m_pull ? 1'b0 : 1'b1; // Pull-up on the open drain line

    nbc_host dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
        .i_op(i_op), .i_data(i_data), .i_addr(i_addr), .i_wide(i_wide),
        .i_protect(i_protect), .o_ready(o_ready), .o_done(o_done),
        .o_rdata(o_rdata), .o_busy(o_busy), .o_refused(o_refused),
        .o_ce_b(o_ce_b), .o_cle(o_cle), .o_ale(o_ale),
        .o_write_strobe_n(o_write_strobe_n),
        .o_read_strobe_n(o_read_strobe_n), .o_wp_b(o_wp_b),
        .i_io(io_bus), .o_io(o_io), .o_io_oe(o_io_oe), .i_rb(rb));

    nbc_flash_model mdl (.i_clk(i_clk), .i_ce_b(o_ce_b), .i_cle(o_cle),
        .i_ale(o_ale), .i_write_strobe_n(o_write_strobe_n),
        .i_read_strobe_n(o_read_strobe_n), .i_wp_b(o_wp_b),
        .i_wide(i_wide), .i_io(io_bus), .o_io(m_io), .o_pull_rb(m_pull));

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    // Clock, 10 ns period
    initial forever #5 i_clk = ~i_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One request; pins are sampled in the first strobe-low cycle
    task automatic run(input logic [2:0] op, input logic [15:0] d,
                       input logic rf);
        int k;
        check(o_ready, 1'b1);
        i_op = op;
        i_data = d;
        i_req = 1'b1;
        @(negedge i_clk);
        i_req = 1'b0;
        check(o_ready, rf);
        pins = {o_ce_b, o_cle, o_ale, o_write_strobe_n, o_read_strobe_n};
        oe_seen = o_io_oe;
        for (k = 0; k < 60 && o_done !== 1'b1 && o_refused !== 1'b1; k++)
            @(negedge i_clk);
        check(o_refused, rf);
        check(o_done, !rf);
    endtask

    // Waits out a busy period; the host needs two ready samples
    task automatic wait_idle;
        int k;
        for (k = 0; k < 100 && o_busy !== 1'b0; k++) @(negedge i_clk);
        repeat (3) @(negedge i_clk);
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_idle;
        check({o_ce_b, o_cle, o_ale, o_write_strobe_n, o_read_strobe_n},
              5'b10011);
        check(o_io_oe, 16'h0000);
    endtask

    // Every listed code once, busy waited out after confirms
    task automatic t_codes;
        logic [7:0] c [0:17];
        int i;
        c = '{8'h00, 8'h30, 8'h35, 8'h31, 8'h3F, 8'h05, 8'hE0, 8'h90,
              8'h70, 8'h7B, 8'hFF, 8'h80, 8'h85, 8'h10, 8'h11, 8'h81,
              8'h60, 8'hD0};
        for (i = 0; i < 18; i++) begin
            run(nbc_pkg::NBC_OP_CMD, {8'h00, c[i]}, 1'b0);
            check(mdl.cmd_q, c[i]);
            check(pins, 5'b01001);
            check(oe_seen, 16'h00FF);
            wait_idle();
        end
    endtask

    // Five address cycles with unused lines low
    task automatic t_addr(input logic w);
        logic [15:0] e [0:4];
        logic [`NBC_ADDR_W-1:0] a;
        int j;
        a = 29'h1ABCDEF5;
        if (w) begin
            e = '{{8'h00, a[7:0]}, {13'h0, a[10:8]}, {8'h00, a[18:11]},
                  {8'h00, a[26:19]}, {15'h0, a[27]}};
        end else begin
            e = '{{8'h00, a[7:0]}, {12'h0, a[11:8]}, {8'h00, a[19:12]},
                  {8'h00, a[27:20]}, {15'h0, a[28]}};
        end
        i_wide = w;
        i_addr = a;
        run(nbc_pkg::NBC_OP_CMD, 16'h0000, 1'b0);
        run(nbc_pkg::NBC_OP_ADDR5, 16'h0000, 1'b0);
        check(pins, 5'b00101);
        check(mdl.n_adr, 5);
        for (j = 0; j < 5; j++)
            check(mdl.adr_q[j], e[j]);
    endtask

    // Two reads back to back; byte mode keeps upper lines out
    task automatic t_read(input logic w);
        i_wide = w;
        run(nbc_pkg::NBC_OP_CMD, 16'h0005, 1'b0);
        run(nbc_pkg::NBC_OP_RDATA, 16'h0000, 1'b0);
        check(o_rdata, w ? 16'hC3A0 : 16'h00A0);
        check(pins, 5'b00010);
        check(oe_seen, 16'h0000);
        run(nbc_pkg::NBC_OP_RDATA, 16'h0000, 1'b0);
        check(o_rdata, w ? 16'hC3A1 : 16'h00A1);
    endtask

    // Data load, confirm, then commands during busy
    task automatic t_prog(input logic w);
        i_wide = w;
        run(nbc_pkg::NBC_OP_CMD, 16'h0080, 1'b0);
        run(nbc_pkg::NBC_OP_WDATA, 16'h5AC3, 1'b0);
        check(mdl.din_q, w ? 16'h5AC3 : 16'h00C3);
        check(oe_seen, w ? 16'hFFFF : 16'h00FF);
        check(pins, 5'b00001);
        run(nbc_pkg::NBC_OP_CMD, 16'h0010, 1'b0);
        check(o_busy, 1'b1);
        run(nbc_pkg::NBC_OP_CMD, 16'h0090, 1'b1);
        check(mdl.cmd_q, 8'h10);
        run(nbc_pkg::NBC_OP_CMD, 16'h0070, 1'b0);
        check(mdl.cmd_q, 8'h70);
        wait_idle();
        check(o_busy, 1'b0);
    endtask

    // Erase code refused with protection on; reads still allowed
    task automatic t_protect;
        i_protect = 1'b0;
        @(negedge i_clk);
        check(o_wp_b, 1'b0);
        run(nbc_pkg::NBC_OP_CMD, 16'h0060, 1'b1);
        check(mdl.cmd_q, 8'h70);
        run(nbc_pkg::NBC_OP_CMD, 16'h0090, 1'b0);
        check(mdl.cmd_q, 8'h90);
        // Single address byte in word mode keeps the upper lines low
        run(nbc_pkg::NBC_OP_ADDR, 16'hA55A, 1'b0);
        check(mdl.adr_q[0], 16'h005A);
        // Unknown operation code is refused with no pin activity
        run(3'h7, 16'h0000, 1'b1);
        i_protect = 1'b1;
        @(negedge i_clk);
    endtask

    // -----------------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------------
    // Reset held 8 cycles, then each scenario in turn
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_b = 1'b1;
        t_idle();
        t_codes();
        t_addr(1'b0);
        t_addr(1'b1);
        t_read(1'b0);
        t_read(1'b1);
        t_prog(1'b0);
        t_prog(1'b1);
        t_protect();
        t_idle();
        conclude();
    end

    // Run needs a few hundred cycles; far past that means a hang
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule

// ### verif/nbc_flash_model.sv
/*
 * Stand-in for the flash device: latches command, address and data on
 * the write strobe rise, drives counted words on read strobe falls and
 * pulls the busy line low while a modify operation runs.
 * Assumes a single host and a pull-up on the busy line in the bench.
 */
`timescale 1ns/10ps

module nbc_flash_model (
    // Clock for the busy countdown
    input  wire logic        i_clk,
    // Device pins
    input  wire logic        i_ce_b,
    input  wire logic        i_cle,
    input  wire logic        i_ale,
    input  wire logic        i_write_strobe_n,
    input  wire logic        i_read_strobe_n,
    input  wire logic        i_wp_b,
    input  wire logic        i_wide,
    input  wire logic [15:0] i_io,
    output logic      [15:0] o_io,
    output logic             o_pull_rb
);
    logic [7:0]  cmd_q = 8'h00;
    logic [15:0] adr_q [0:4];
    logic [15:0] din_q = 16'h0000;
    logic [15:0] dout  = 16'h0000;
    logic        drv   = 1'b0;
    logic        take;
    int          n_adr = 0;
    int          col   = 0;
    int          busy_cnt = 0;

    // While busy only status and reset codes get through
    assign take = busy_cnt == 0 || i_io[7:0] == 8'h70
                  || i_io[7:0] == 8'hFF;

    // Latch only on write strobe rise and only while selected
    always @(posedge i_write_strobe_n) begin
        if (!i_ce_b && i_read_strobe_n) begin
            if (i_cle && !i_ale && take) begin
                cmd_q = i_io[7:0];
                n_adr = 0;
                col = 0;
                if (i_wp_b && (cmd_q == 8'h10 || cmd_q == 8'hD0))
                    busy_cnt = 20;
            end else if (i_ale && !i_cle && n_adr < 5) begin
                adr_q[n_adr] = i_wide ? i_io : {8'h00, i_io[7:0]};
                n_adr++;
            end else if (!i_cle && !i_ale && i_wp_b) begin
                din_q = i_wide ? i_io : {8'h00, i_io[7:0]};
            end
        end
    end

    // Next word on each read strobe fall
    always @(negedge i_read_strobe_n) begin
        if (!i_ce_b && !i_cle && !i_ale && i_write_strobe_n) begin
            dout = 16'hC3A0 + col[15:0];
            col++;
            drv = 1'b1;
        end
    end

    // Deselect only floats the bus; the column count carries on
    always @(posedge i_read_strobe_n or posedge i_ce_b) drv = 1'b0;

    // Busy countdown in clock cycles
    // Non-blocking so the host samples the old level at the same edge
    always @(posedge i_clk) if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;

    // Released bus shows the inverse so a stale word cannot pass
    assign o_io = (drv && !i_ce_b) ? dout : ~dout;
    assign o_pull_rb = busy_cnt > 0;
endmodule
